// *** rtl/sram_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module sram_ctrl #(
    parameter bit SLOW_GRADE      = 1'b0,
    parameter int RECOVERY_CYCLES = sram_ctrl_pkg::RETENTION_EXIT_WAIT_CYC
) (
    input  wire logic                              clk_sys,
    input  wire logic                              rst,
    input  wire logic                              req_valid,
    input  wire logic                              req_write,
    input  wire logic [sram_ctrl_pkg::ADDR_W-1:0]  req_addr,
    input  wire logic [sram_ctrl_pkg::DATA_W-1:0]  req_wdata,
    output logic                                   req_ready,
    output logic                                   rsp_valid,
    output logic      [sram_ctrl_pkg::DATA_W-1:0]  rsp_rdata,
    input  wire logic                              retention_req,
    output logic                                   retention_ack,
    output logic      [sram_ctrl_pkg::ADDR_W-1:0]  sram_addr,
    output logic                                   sram_cs_n,
    output logic                                   sram_we_n,
    output logic                                   sram_oe_n,
    input  wire logic [sram_ctrl_pkg::DATA_W-1:0]  sram_dq_i,
    output logic      [sram_ctrl_pkg::DATA_W-1:0]  sram_dq_o,
    output logic                                   sram_dq_oe
);

    localparam int CW = sram_ctrl_pkg::CNT_W;
    localparam logic [CW-1:0] READ_LOAD = CW'((SLOW_GRADE ? sram_ctrl_pkg::READ_CYC_SLOW
                                                          : sram_ctrl_pkg::READ_CYC_FAST) - 1);
    localparam logic [CW-1:0] WE_LOAD   = CW'((SLOW_GRADE ? sram_ctrl_pkg::WE_CYC_SLOW
                                                          : sram_ctrl_pkg::WE_CYC_FAST) - 1);
    localparam logic [CW-1:0] TURN_LOAD = CW'((SLOW_GRADE ? sram_ctrl_pkg::TURN_CYC_SLOW
                                                          : sram_ctrl_pkg::TURN_CYC_FAST) - 1);
    localparam logic [CW-1:0] REC_LOAD  = CW'(RECOVERY_CYCLES - 1);

    sram_ctrl_pkg::state_type             state_ff;
    sram_ctrl_pkg::state_type             nxt_state;
    logic [CW-1:0]                        cnt_ff;
    logic [CW-1:0]                        nxt_cnt;
    logic [sram_ctrl_pkg::DATA_W-1:0]     dq_s1_ff;
    logic [sram_ctrl_pkg::DATA_W-1:0]     dq_s2_ff;
    logic [sram_ctrl_pkg::DATA_W-1:0]     dq_s3_ff;
    logic [sram_ctrl_pkg::DATA_W-1:0]     dq_stable_ff;
    logic                                 ret_s1_ff;
    logic                                 ret_s2_ff;
    logic                                 ret_s3_ff;
    logic                                 ret_stable_ff;
    logic                                 req_ready_ff;
    logic                                 rsp_valid_ff;
    logic [sram_ctrl_pkg::DATA_W-1:0]     rsp_rdata_ff;
    logic                                 retention_ack_ff;
    logic [sram_ctrl_pkg::ADDR_W-1:0]     addr_ff;
    logic                                 cs_n_ff;
    logic                                 we_n_ff;
    logic                                 oe_n_ff;
    logic [sram_ctrl_pkg::DATA_W-1:0]     dq_o_ff;
    logic                                 dq_oe_ff;

    // Taken only from idle, once ready has already been shown
    wire       accept    = (state_ff == sram_ctrl_pkg::st_idle) && req_valid && req_ready_ff;
    wire       cnt_done  = (cnt_ff == '0);
    // Parks at zero, so a stray extra cycle never wraps the count
    wire [CW-1:0] cnt_dec = cnt_done ? cnt_ff : cnt_ff - CW'(1);
    wire       read_done = (state_ff == sram_ctrl_pkg::st_read) && cnt_done;

    // Select low only inside an access, so retention and idle keep it high
    wire nxt_cs_n  = !((nxt_state == sram_ctrl_pkg::st_read) ||
                       (nxt_state == sram_ctrl_pkg::st_write));              // [R15] [R17]
    // Strobe falls on the same edge as select, keeping the memory off the bus
    wire nxt_we_n  = (nxt_state != sram_ctrl_pkg::st_write);                 // [R1] [R2]
    wire nxt_oe_n  = (nxt_state != sram_ctrl_pkg::st_read);                  // [R18]
    // Drive only during writes; reads end with a release gap first
    wire nxt_dq_oe = (nxt_state == sram_ctrl_pkg::st_write) ||
                     (nxt_state == sram_ctrl_pkg::st_wend);                  // [R3] [R20]
    wire nxt_ready = (nxt_state == sram_ctrl_pkg::st_idle) && !accept;
    // Acknowledge follows the next state, so it rises on the same edge that retention is entered
    wire nxt_ack   = (nxt_state == sram_ctrl_pkg::st_retain);

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_dec;
        case (state_ff)
            sram_ctrl_pkg::st_idle: begin
                // Retention only from idle or recovery, so an access in flight always completes
                if (accept) begin
                    nxt_state = req_write ? sram_ctrl_pkg::st_write : sram_ctrl_pkg::st_read;
                    nxt_cnt   = req_write ? WE_LOAD : READ_LOAD;            // [R5] [R6] [R12]
                end else if (ret_stable_ff) begin
                    nxt_state = sram_ctrl_pkg::st_retain;
                end
            end
            sram_ctrl_pkg::st_read: begin
                // Pins hold the read pattern until the synchronised byte is in
                if (cnt_done) begin
                    nxt_state = sram_ctrl_pkg::st_turn;
                    nxt_cnt   = TURN_LOAD;                                   // [R7] [R9]
                end
            end
            sram_ctrl_pkg::st_turn: begin
                if (cnt_done) begin
                    nxt_state = sram_ctrl_pkg::st_idle;
                end
            end
            sram_ctrl_pkg::st_write: begin
                if (cnt_done) begin
                    nxt_state = sram_ctrl_pkg::st_wend;                      // [R11] [R19]
                end
            end
            sram_ctrl_pkg::st_wend: begin
                // Select and strobe already high; data stays one cycle for hold
                nxt_state = sram_ctrl_pkg::st_idle;
            end
            sram_ctrl_pkg::st_retain: begin
                if (!ret_stable_ff) begin
                    nxt_state = sram_ctrl_pkg::st_recover;
                    nxt_cnt   = REC_LOAD;                                    // [R16]
                end
            end
            sram_ctrl_pkg::st_recover: begin
                // A fresh drop of supply restarts the whole wait
                if (ret_stable_ff) begin
                    nxt_state = sram_ctrl_pkg::st_retain;
                end else if (cnt_done) begin
                    nxt_state = sram_ctrl_pkg::st_idle;
                end
            end
            default: begin
                // Unused encodings fall back to idle
                nxt_state = sram_ctrl_pkg::st_idle;
                nxt_cnt   = '0;
            end
        endcase
    end

    // Three stages; a change counts only once the last two agree
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dq_s1_ff      <= sram_ctrl_pkg::DQ_RESET;
            dq_s2_ff      <= sram_ctrl_pkg::DQ_RESET;
            dq_s3_ff      <= sram_ctrl_pkg::DQ_RESET;
            dq_stable_ff  <= sram_ctrl_pkg::DQ_RESET;
            ret_s1_ff     <= 1'b0;
            ret_s2_ff     <= 1'b0;
            ret_s3_ff     <= 1'b0;
            ret_stable_ff <= 1'b0;
        end else begin
            dq_s1_ff  <= sram_dq_i;
            dq_s2_ff  <= dq_s1_ff;
            dq_s3_ff  <= dq_s2_ff;
            ret_s1_ff <= retention_req;
            ret_s2_ff <= ret_s1_ff;
            ret_s3_ff <= ret_s2_ff;
            if (dq_s2_ff == dq_s3_ff) begin
                dq_stable_ff <= dq_s3_ff;
            end
            if (ret_s2_ff == ret_s3_ff) begin
                ret_stable_ff <= ret_s3_ff;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_ff <= sram_ctrl_pkg::st_idle;
            cnt_ff   <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cs_n_ff          <= 1'b1;
            we_n_ff          <= 1'b1;
            oe_n_ff          <= 1'b1;
            dq_oe_ff         <= 1'b0;
            req_ready_ff     <= 1'b0;
            retention_ack_ff <= 1'b0;
        end else begin
            cs_n_ff          <= nxt_cs_n;
            we_n_ff          <= nxt_we_n;
            oe_n_ff          <= nxt_oe_n;
            dq_oe_ff         <= nxt_dq_oe;
            req_ready_ff     <= nxt_ready;
            retention_ack_ff <= nxt_ack;
        end
    end

    // Address and data stay put until the next accepted request
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            addr_ff      <= sram_ctrl_pkg::ADDR_RESET;
            dq_o_ff      <= sram_ctrl_pkg::DQ_RESET;
            rsp_valid_ff <= 1'b0;
            rsp_rdata_ff <= sram_ctrl_pkg::DQ_RESET;
        end else begin
            if (accept) begin
                addr_ff <= req_addr;                                         // [R11]
                dq_o_ff <= req_wdata;                                        // [R20]
            end
            rsp_valid_ff <= read_done;
            if (read_done) begin
                rsp_rdata_ff <= dq_stable_ff;                                // [R5] [R6]
            end
        end
    end

    // Every output straight from a flip-flop, so no glitch reaches the pins
    assign req_ready     = req_ready_ff;
    assign rsp_valid     = rsp_valid_ff;
    assign rsp_rdata     = rsp_rdata_ff;
    assign retention_ack = retention_ack_ff;
    assign sram_addr     = addr_ff;
    assign sram_cs_n     = cs_n_ff;
    assign sram_we_n     = we_n_ff;
    assign sram_oe_n     = oe_n_ff;
    assign sram_dq_o     = dq_o_ff;
    assign sram_dq_oe    = dq_oe_ff;

endmodule : sram_ctrl
`default_nettype wire

// *** rtl/sram_ctrl_pkg.sv ***
// Functional notes
// R1: The memory writes only while chip select and write strobe overlap low.
// R2: Strobe falling with or before chip select keeps memory outputs off.
// R3: Controller never drives the data bus while the memory drives it.
// R4: Memory holds old read data at least 10 ns after address change.
// R5: Read data valid within 55 or 70 ns of chip select low.
// R6: Read data valid within 25 or 35 ns of output enable low.
// R7: Memory releases the bus within 20 or 25 ns of chip select high.
// R8: Memory starts driving no sooner than 10 ns after chip select low.
// R9: Memory releases the bus within 20 or 25 ns of output enable high.
// R10: Memory starts driving no sooner than 5 ns after output enable low.
// R11: Address stable at least 50 or 60 ns before write strobe rises.
// R12: Chip select low at least 50 or 60 ns before a write ends.
// R13: Memory releases the bus within 20 or 25 ns of write strobe low.
// R14: Memory starts driving no sooner than 5 ns after write strobe high.
// R15: Chip select goes high no later than supply drop into retention.
// R16: Wait at least 5 ms after retention ends before any access.
// R17: Chip select held deasserted throughout data retention.
// R18: With select low and strobe high, memory drives only while output enable low.
// R19: Space accesses by cycle time; keep write strobe low the minimum width.
// R20: Write data set up before window end and held until it closes.
package sram_ctrl_pkg;

    localparam int CLK_PERIOD_NS = 25;
    localparam int ADDR_W        = 19;
    localparam int DATA_W        = 8;
    localparam int SYNC_STAGES   = 3;

    // Timing figures, fast grade then slow grade
    localparam int T_ACC_S_FAST_NS   = 55;
    localparam int T_ACC_S_SLOW_NS   = 70;
    localparam int T_ACC_OE_FAST_NS  = 25;
    localparam int T_ACC_OE_SLOW_NS  = 35;
    localparam int T_DIS_FAST_NS     = 20;
    localparam int T_DIS_SLOW_NS     = 25;
    localparam int T_SU_S_FAST_NS    = 50;
    localparam int T_SU_S_SLOW_NS    = 60;
    localparam int T_SU_AWH_FAST_NS  = 50;
    localparam int T_SU_AWH_SLOW_NS  = 60;
    localparam int T_WP_FAST_NS      = 40;
    localparam int T_WP_SLOW_NS      = 50;
    localparam int T_CYC_FAST_NS     = 55;
    localparam int T_CYC_SLOW_NS     = 70;
    localparam int RETENTION_ENTRY_SETUP_NS = 0;
    localparam int RETENTION_EXIT_WAIT_MS   = 5;

    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction : max2

    // Least times round up, longest round down; never below one cycle
    function automatic int cyc_min(input int ns);
        return max2((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS, 1);
    endfunction : cyc_min

    function automatic int cyc_max(input int ns);
        return max2(ns / CLK_PERIOD_NS, 1);
    endfunction : cyc_max

    // Read: worst access, then the pin synchroniser and its agree stage
    localparam int READ_CYC_FAST = cyc_min(max2(T_ACC_S_FAST_NS, T_ACC_OE_FAST_NS))
                                   + SYNC_STAGES + 1;
    localparam int READ_CYC_SLOW = cyc_min(max2(T_ACC_S_SLOW_NS, T_ACC_OE_SLOW_NS))
                                   + SYNC_STAGES + 1;
    // Write strobe low time; the closing cycle adds one more to the cycle time
    localparam int WE_CYC_FAST = max2(max2(cyc_min(T_SU_S_FAST_NS), cyc_min(T_SU_AWH_FAST_NS)),
                                      max2(cyc_min(T_WP_FAST_NS), cyc_min(T_CYC_FAST_NS) - 1));
    localparam int WE_CYC_SLOW = max2(max2(cyc_min(T_SU_S_SLOW_NS), cyc_min(T_SU_AWH_SLOW_NS)),
                                      max2(cyc_min(T_WP_SLOW_NS), cyc_min(T_CYC_SLOW_NS) - 1));
    localparam int TURN_CYC_FAST = cyc_max(T_DIS_FAST_NS);
    localparam int TURN_CYC_SLOW = cyc_max(T_DIS_SLOW_NS);
    localparam int RETENTION_EXIT_WAIT_CYC =
        RETENTION_EXIT_WAIT_MS * 1000000 / CLK_PERIOD_NS;

    localparam int CNT_W = 18;

    localparam logic [DATA_W-1:0] DQ_RESET   = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 19'h00000;

    typedef enum logic [2:0] {
        st_idle,
        st_read,
        st_turn,
        st_write,
        st_wend,
        st_retain,
        st_recover
    } state_type;

endpackage : sram_ctrl_pkg

// *** testbench/sram_ctrl_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module sram_ctrl_asserts #(
    parameter bit SLOW_GRADE      = 1'b0,
    parameter int RECOVERY_CYCLES = 20
) (
    input wire logic                             clk_sys,
    input wire logic                             rst,
    input wire logic                             rsp_valid,
    input wire logic                             retention_ack,
    input wire logic [sram_ctrl_pkg::ADDR_W-1:0] sram_addr,
    input wire logic                             sram_cs_n,
    input wire logic                             sram_we_n,
    input wire logic                             sram_oe_n,
    input wire logic [sram_ctrl_pkg::DATA_W-1:0] sram_dq_o,
    input wire logic                             sram_dq_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Cycles since select was last held off for retention
    int rec_cnt_ff;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) rec_cnt_ff <= RECOVERY_CYCLES;
        else if (retention_ack) rec_cnt_ff <= 0;
        else if (rec_cnt_ff < RECOVERY_CYCLES) rec_cnt_ff <= rec_cnt_ff + 1;
    end
    no_contention_a: assert property (sram_dq_oe |-> sram_oe_n)
        else $error("data driven while output enable low");
    write_qual_a: assert property (!sram_we_n |-> !sram_cs_n && sram_oe_n)
        else $error("strobe low without select or with output enable");
    strobe_width_a: assert property ($fell(sram_we_n) && !SLOW_GRADE |->
        (!sram_we_n && !sram_cs_n)[*2] ##1 (sram_we_n && sram_cs_n))
        else $error("write strobe width wrong");
    strobe_slow_a: assert property ($fell(sram_we_n) && SLOW_GRADE |->
        (!sram_we_n && !sram_cs_n)[*3] ##1 (sram_we_n && sram_cs_n))
        else $error("slow grade write strobe width wrong");
    addr_stable_a: assert property (!sram_cs_n && !$past(sram_cs_n) |-> $stable(sram_addr))
        else $error("address moved during access");
    data_setup_a: assert property ($fell(sram_we_n) |->
        sram_dq_oe ##1 (sram_dq_oe && $stable(sram_dq_o))[*2])
        else $error("write data not set up");
    data_hold_a: assert property ($rose(sram_we_n) |-> sram_dq_oe)
        else $error("write data not held");
    read_width_a: assert property ($fell(sram_oe_n) |->
        !sram_oe_n[*7] ##1 sram_oe_n)
        else $error("read window length wrong");
    read_answer_a: assert property ($rose(sram_cs_n) && !$rose(sram_we_n) |-> rsp_valid)
        else $error("read end without answer");
    retain_desel_a: assert property (retention_ack |-> sram_cs_n)
        else $error("select low in retention");
    recovery_wait_a: assert property ($fell(sram_cs_n) |-> rec_cnt_ff >= RECOVERY_CYCLES - 2)
        else $error("access too soon after retention");
endmodule : sram_ctrl_asserts
`default_nettype wire

// *** testbench/sram_ctrl_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module sram_ctrl_tb_top;
    localparam int RECOVERY_CYCLES = 20;
    logic        clk_sys, rst, req_valid, req_write, req_ready, rsp_valid;
    logic        retention_req, retention_ack, sram_cs_n, sram_we_n, sram_oe_n, sram_dq_oe;
    logic [18:0] req_addr, sram_addr;
    logic [7:0]  req_wdata, rsp_rdata, sram_dq_i, sram_dq_o;
    logic [31:0] seed;
    logic [7:0]  exp_mem [int];
    int          error_cnt, compares, cyc;
    logic        req_ready_slow, rsp_valid_slow, retention_ack_slow, sram_cs_n_slow, slow_sel;
    logic        sram_we_n_slow, sram_oe_n_slow, sram_dq_oe_slow;
    logic [18:0] sram_addr_slow;
    logic [7:0]  rsp_rdata_slow, sram_dq_i_slow, sram_dq_o_slow;
    // Handshake follows whichever grade is under test
    wire logic       ready_sel = slow_sel ? req_ready_slow : req_ready;
    wire logic       valid_sel = slow_sel ? rsp_valid_slow : rsp_valid;
    wire logic [7:0] rdata_sel = slow_sel ? rsp_rdata_slow : rsp_rdata;

    sram_ctrl #(.SLOW_GRADE(1'b0), .RECOVERY_CYCLES(RECOVERY_CYCLES)) i_sram_ctrl (
        .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .retention_req(retention_req),
        .retention_ack(retention_ack), .sram_addr(sram_addr), .sram_cs_n(sram_cs_n),
        .sram_we_n(sram_we_n), .sram_oe_n(sram_oe_n), .sram_dq_i(sram_dq_i),
        .sram_dq_o(sram_dq_o), .sram_dq_oe(sram_dq_oe));
    sram_model i_sram_model (.sram_addr(sram_addr), .sram_cs_n(sram_cs_n),
        .sram_we_n(sram_we_n), .sram_oe_n(sram_oe_n), .ctrl_dq(sram_dq_o),
        .ctrl_dq_oe(sram_dq_oe), .bus_dq(sram_dq_i));
    sram_ctrl #(.SLOW_GRADE(1'b1), .RECOVERY_CYCLES(RECOVERY_CYCLES)) i_sram_ctrl_slow (
        .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready_slow),
        .rsp_valid(rsp_valid_slow), .rsp_rdata(rsp_rdata_slow),
        .retention_req(retention_req), .retention_ack(retention_ack_slow),
        .sram_addr(sram_addr_slow), .sram_cs_n(sram_cs_n_slow),
        .sram_we_n(sram_we_n_slow), .sram_oe_n(sram_oe_n_slow), .sram_dq_i(sram_dq_i_slow),
        .sram_dq_o(sram_dq_o_slow), .sram_dq_oe(sram_dq_oe_slow));
    sram_model i_sram_model_slow (.sram_addr(sram_addr_slow), .sram_cs_n(sram_cs_n_slow),
        .sram_we_n(sram_we_n_slow), .sram_oe_n(sram_oe_n_slow), .ctrl_dq(sram_dq_o_slow),
        .ctrl_dq_oe(sram_dq_oe_slow), .bus_dq(sram_dq_i_slow));

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xorshift
    task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_data
    task automatic chk_ctl(input logic [4:0] got, input logic [4:0] exp);
        chk_data({3'h0, got}, {3'h0, exp});
    endtask : chk_ctl
    task automatic tick;
        @(posedge clk_sys);
        #2;
    endtask : tick
    // Request held until taken; reads then wait for the answer
    task automatic access(input logic wr, input logic [18:0] a, input logic [7:0] d);
        int n;
        n = 0;
        tick();
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        while (ready_sel !== 1'b1 && n < 100) begin
            tick();
            n++;
        end
        tick();
        req_valid = 1'b0;
        if (wr) exp_mem[a] = d;
        n = 0;
        while (!wr && valid_sel !== 1'b1 && n < 20) begin
            tick();
            n++;
        end
        if (!wr) chk_data({7'h00, valid_sel}, 8'h01);
        if (!wr) chk_data(rdata_sel, exp_mem[a]);
    endtask : access
    task automatic summarize;
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // Whole run needs well under a thousand cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc > 20000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        int t0;
        rst = 1'b1;
        {req_valid, req_write, retention_req} = 3'h0;
        slow_sel = 1'b0;
        req_addr = 19'h00000;
        req_wdata = 8'h00;
        seed = 32'h0000a092;
        repeat (20) @(posedge clk_sys);
        #2;
        chk_ctl({sram_cs_n, sram_we_n, sram_oe_n, sram_dq_oe, req_ready}, 5'h1c);
        chk_ctl({sram_cs_n_slow, sram_we_n_slow, sram_oe_n_slow, sram_dq_oe_slow,
                 req_ready_slow}, 5'h1c);
        rst = 1'b0;
        access(1'b1, 19'h7ffff, 8'hff);
        access(1'b1, 19'h00000, 8'h00);
        access(1'b0, 19'h7ffff, 8'h00);
        access(1'b0, 19'h00000, 8'h00);
        $display("test corners done");
        for (int i = 0; i < 8; i++) access(1'b1, {i[2:0], 16'h0000}, 8'(i * 37));
        for (int i = 0; i < 40; i++) begin
            seed = xorshift(seed);
            access(seed[0], {seed[12:10], 16'h0000}, seed[31:24]);
        end
        $display("test random done");
        tick();
        retention_req = 1'b1;
        t0 = 0;
        while (retention_ack !== 1'b1 && t0 < 20) begin
            tick();
            t0++;
        end
        req_valid = 1'b1;
        repeat (10) tick();
        chk_ctl({sram_cs_n, sram_we_n, sram_oe_n, retention_ack, req_ready}, 5'h1e);
        chk_ctl({sram_cs_n_slow, sram_we_n_slow, sram_oe_n_slow, retention_ack_slow,
                 req_ready_slow}, 5'h1e);
        retention_req = 1'b0;
        t0 = cyc;
        access(1'b0, 19'h7ffff, 8'h00);
        chk_data({7'h00, (cyc - t0) >= RECOVERY_CYCLES}, 8'h01);
        $display("test retention done");
        // Slow grade missed some earlier requests, so it is filled afresh first
        slow_sel = 1'b1;
        for (int i = 0; i < 8; i++) access(1'b1, {i[2:0], 16'h0000}, 8'(i * 59));
        for (int i = 0; i < 16; i++) begin
            seed = xorshift(seed);
            access(seed[0], {seed[12:10], 16'h0000}, seed[31:24]);
        end
        $display("test slow grade done");
        summarize();
    end
endmodule : sram_ctrl_tb_top
bind sram_ctrl sram_ctrl_asserts #(
    .SLOW_GRADE(SLOW_GRADE), .RECOVERY_CYCLES(RECOVERY_CYCLES)) i_sram_ctrl_asserts (
    .clk_sys(clk_sys), .rst(rst), .rsp_valid(rsp_valid), .retention_ack(retention_ack),
    .sram_addr(sram_addr), .sram_cs_n(sram_cs_n), .sram_we_n(sram_we_n),
    .sram_oe_n(sram_oe_n), .sram_dq_o(sram_dq_o), .sram_dq_oe(sram_dq_oe));
`default_nettype wire

// *** testbench/sram_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sram_model (
    input  wire logic [18:0] sram_addr,
    input  wire logic        sram_cs_n,
    input  wire logic        sram_we_n,
    input  wire logic        sram_oe_n,
    input  wire logic [7:0]  ctrl_dq,
    input  wire logic        ctrl_dq_oe,
    output logic      [7:0]  bus_dq
);
    logic [7:0] mem [0:524287];
    logic [7:0] rd_q;
    logic       drv;
    // Store as the select/strobe overlap closes
    always @(posedge (sram_cs_n | sram_we_n)) begin
        if (ctrl_dq_oe) mem[sram_addr] <= ctrl_dq;
    end
    assign #10 rd_q = mem[sram_addr];
    assign #10 drv = !sram_cs_n && sram_we_n && !sram_oe_n;
    // Released bus shows inverted data, never a friendly stale value
    assign bus_dq = ctrl_dq_oe ? ctrl_dq : (drv ? rd_q : ~rd_q);
endmodule : sram_model
`default_nettype wire
